// >>> src/lvte_consts.vh
// Constants shared by the LAN egress VLAN tag editor and its FCS engine.
// Assumes plain Verilog-2005 includes by bare file name.
`ifndef LVTE_CONSTS_VH
`define LVTE_CONSTS_VH

// ****************************************
// Tag operation codes
// ****************************************
`define LVTE_OP_KEEP     2'h0
`define LVTE_OP_ADD      2'h1
`define LVTE_OP_REMOVE   2'h2
`define LVTE_OP_REWRITE  2'h3

// ****************************************
// Frame layout and tag values
// ****************************************
`define LVTE_TAG_POS     4'hC
`define LVTE_BODY_POS    4'hE
`define LVTE_TPID_C      16'h8100
`define LVTE_TPID_S      16'h88A8
`define LVTE_VID_MAX     12'hFFE

// ****************************************
// Configuration reset values
// ****************************************
`define LVTE_RST_OP      2'h0
`define LVTE_RST_PKEEP   1'h1
`define LVTE_RST_PCP     3'h0
`define LVTE_RST_VID     12'h000

// ****************************************
// Frame check sequence
// ****************************************
`define LVTE_CRC_POLY    32'hEDB88320
`define LVTE_CRC_INIT    32'hFFFFFFFF
`define LVTE_FCS_LAST    2'h3

`endif

// >>> src/lvte_crc32.v
// Running Ethernet CRC-32 over the transmitted byte stream.
// Assumes bytes arrive one per enabled cycle, first byte flagged by init.
`timescale 1ns/1ps
`include "lvte_consts.vh"

module lvte_crc32 (
  // Clock and reset
  input  wire        sys_clk,
  input  wire        rst_n,
  input  wire        ce,
  // Byte feed
  input  wire        en,
  input  wire        init,
  input  wire [7:0]  data,
  // Running remainder
  output reg  [31:0] crc_reg
);

  // ****************************************
  // Bitwise reflected update
  // ****************************************
  function [31:0] crc_byte;
    input [31:0] c;
    input [7:0]  d;
    integer      i;
    reg   [31:0] r;
    begin
      r = c ^ {24'h000000, d};
      for (i = 0; i < 8; i = i + 1) begin
        r = r[0] ? ((r >> 1) ^ `LVTE_CRC_POLY) : (r >> 1);
      end
      crc_byte = r;
    end
  endfunction

  // Restart on the first byte so no stale remainder leaks between frames
  always @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      crc_reg <= `LVTE_CRC_INIT;
    end else if (ce && en) begin
      crc_reg <= crc_byte(init ? `LVTE_CRC_INIT : crc_reg, data);
    end
  end

endmodule // lvte_crc32

// >>> src/lvte_tag_editor.v
// Per-port VLAN tag editor for frames leaving through four LAN ports.
// Assumes input frames come without FCS, one byte per accepted cycle;
// the link side takes every output byte (no output back-pressure).
`timescale 1ns/1ps
`include "lvte_consts.vh"

// What this block does
// - Each of four ports keeps its own operation, priority and VLAN identifier.
// - Keep operation forwards tag fields exactly as received.
// - Add inserts configured tag into untagged frames only; tagged frames pass.
// - Remove strips the single outer tag; untagged frames pass unaltered.
// - Rewrite overwrites outer tag VLAN identifier and priority with configured values.
// - Priority is keep-existing or 0 to 7, used when adding or rewriting.
// - VLAN identifier accepts 0 through 4094; larger writes are refused.
module lvte_tag_editor #(
  parameter PORTS = 4
) (
  // Clock, reset, enable
  input  wire                 sys_clk,
  input  wire                 rst_n,
  input  wire                 ce,
  // Port configuration write
  input  wire                 cfg_wr,
  input  wire [1:0]           cfg_port,
  input  wire [1:0]           cfg_op,
  input  wire                 cfg_pkeep,
  input  wire [2:0]           cfg_pcp,
  input  wire [11:0]          cfg_vid,
  output reg                  cfg_reject_reg,
  // Frame input from switching fabric
  input  wire                 in_valid,
  input  wire [7:0]           in_data,
  input  wire                 in_sop,
  input  wire                 in_eop,
  input  wire [1:0]           in_port,
  input  wire                 in_down,
  output reg                  in_ready_reg,
  // Frame output toward LAN port
  output reg                  out_valid_reg,
  output reg  [7:0]           out_data_reg,
  output reg                  out_sop_reg,
  output reg                  out_eop_reg,
  output reg  [1:0]           out_port_reg
);

  // ****************************************
  // States and helpers
  // ****************************************
  localparam [2:0] ST_DATA  = 3'b001;
  localparam [2:0] ST_QUEUE = 3'b010;
  localparam [2:0] ST_FCS   = 3'b100;

  // Tag protocol identifiers of a customer or service tag
  function is_tag;
    input [15:0] t;
    begin
      is_tag = (t == `LVTE_TPID_C) || (t == `LVTE_TPID_S);
    end
  endfunction

  // Upper tag control byte: priority, drop bit, high VID nibble
  function [7:0] tci_hi;
    input       pkeep;
    input [2:0] pcp;
    input [2:0] old_pcp;
    input       dei;
    input [11:0] vid;
    begin
      tci_hi = {(pkeep ? old_pcp : pcp), dei, vid[11:8]};
    end
  endfunction

  // ****************************************
  // Per-port configuration
  // ****************************************
  reg [2*PORTS-1:0]  op_reg;
  reg [PORTS-1:0]    pkeep_reg;
  reg [3*PORTS-1:0]  pcp_reg;
  reg [12*PORTS-1:0] vid_reg;
  integer            k;

  // Out-of-range identifiers are dropped whole so a port never runs half-written
  always @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      for (k = 0; k < PORTS; k = k + 1) begin
        op_reg[2*k +: 2]   <= `LVTE_RST_OP;
        pkeep_reg[k]       <= `LVTE_RST_PKEEP;
        pcp_reg[3*k +: 3]  <= `LVTE_RST_PCP;
        vid_reg[12*k +: 12] <= `LVTE_RST_VID;
      end
      cfg_reject_reg <= 1'b0;
    end else if (ce) begin
      cfg_reject_reg <= cfg_wr && (cfg_vid > `LVTE_VID_MAX);
      if (cfg_wr && (cfg_vid <= `LVTE_VID_MAX)) begin
        op_reg[2*cfg_port +: 2]    <= cfg_op;
        pkeep_reg[cfg_port]        <= cfg_pkeep;
        pcp_reg[3*cfg_port +: 3]   <= cfg_pcp;
        vid_reg[12*cfg_port +: 12] <= cfg_vid;
      end
    end
  end

  // ****************************************
  // Frame state
  // ****************************************
  reg [2:0]  st_reg,    st_next;
  reg [47:0] q_reg,     q_next;
  reg [2:0]  qcnt_reg,  qcnt_next;
  reg [3:0]  pos_reg,   pos_next;
  reg [1:0]  skip_reg,  skip_next;
  reg [1:0]  rmk_reg,   rmk_next;
  reg [1:0]  fidx_reg,  fidx_next;
  reg        fpend_reg, fpend_next;
  reg [7:0]  hold_reg,  hold_next;
  reg [1:0]  f_op_reg,  f_op_next;
  reg        f_pk_reg,  f_pk_next;
  reg [2:0]  f_pcp_reg, f_pcp_next;
  reg [11:0] f_vid_reg, f_vid_next;
  reg [1:0]  f_port_reg, f_port_next;
  reg        o_v, o_sop, o_eop;
  reg [7:0]  o_d;
  reg [3:0]  p;
  reg [1:0]  op;
  wire [31:0] crc_w;
  wire        acc = in_valid && in_ready_reg;

  // Next-state and output byte selection
  always @* begin
    st_next = st_reg;      q_next = q_reg;          qcnt_next = qcnt_reg;
    pos_next = pos_reg;    skip_next = skip_reg;    rmk_next = rmk_reg;
    fidx_next = fidx_reg;  fpend_next = fpend_reg;  hold_next = hold_reg;
    f_op_next = f_op_reg;  f_pk_next = f_pk_reg;    f_pcp_next = f_pcp_reg;
    f_vid_next = f_vid_reg; f_port_next = f_port_reg;
    o_v = 1'b0; o_d = 8'h00; o_sop = 1'b0; o_eop = 1'b0;
    p = in_sop ? 4'h0 : pos_reg;
    op = in_sop ? op_reg[2*in_port +: 2] : f_op_reg;
    case (st_reg)
      ST_QUEUE: begin
        o_v = 1'b1;
        o_d = q_reg[47:40];
        q_next = {q_reg[39:0], 8'h00};
        qcnt_next = qcnt_reg - 3'h1;
        if (qcnt_reg == 3'h1) begin
          st_next = fpend_reg ? ST_FCS : ST_DATA;
        end
      end
      ST_FCS: begin
        o_v = 1'b1;
        o_d = ~crc_w[8*fidx_reg +: 8];
        o_eop = (fidx_reg == `LVTE_FCS_LAST);
        fidx_next = fidx_reg + 2'h1;
        if (o_eop) begin
          fpend_next = 1'b0;
          st_next = ST_DATA;
        end
      end
      ST_DATA: begin
        if (acc) begin
          if (in_sop) begin
            // Upstream frames are forced to keep so nothing edits them
            f_op_next   = in_down ? op_reg[2*in_port +: 2] : `LVTE_OP_KEEP;
            op          = f_op_next;
            f_pk_next   = pkeep_reg[in_port];
            f_pcp_next  = pcp_reg[3*in_port +: 3];
            f_vid_next  = vid_reg[12*in_port +: 12];
            f_port_next = in_port;
            skip_next = 2'h0;
            rmk_next = 2'h0;
          end
          pos_next = (p == `LVTE_BODY_POS) ? p : p + 4'h1;
          if (p < `LVTE_TAG_POS || (p == `LVTE_TAG_POS && in_eop)) begin
            o_v = 1'b1; o_d = in_data; o_sop = in_sop;
          end else if (p == `LVTE_TAG_POS) begin
            hold_next = in_data;                     // Wait for full type field
          end else if (p == `LVTE_TAG_POS + 4'h1) begin
            st_next = ST_QUEUE;
            qcnt_next = 3'h2;
            q_next = {hold_reg, in_data, 32'h00000000};
            if (op == `LVTE_OP_ADD && !is_tag({hold_reg, in_data})) begin
              qcnt_next = 3'h6;
              q_next = {`LVTE_TPID_C,
                        tci_hi(f_pk_reg, f_pcp_reg, 3'h0, 1'b0, f_vid_reg),
                        f_vid_reg[7:0], hold_reg, in_data};
            end else if (op == `LVTE_OP_REMOVE && is_tag({hold_reg, in_data})) begin
              st_next = ST_DATA;
              qcnt_next = 3'h0;
              skip_next = 2'h2;
            end else if (op == `LVTE_OP_REWRITE && is_tag({hold_reg, in_data})) begin
              rmk_next = 2'h2;
            end
          end else if (skip_reg != 2'h0) begin
            skip_next = skip_reg - 2'h1;             // Outer control word dropped
          end else if (rmk_reg == 2'h2) begin
            o_v = 1'b1;
            o_d = tci_hi(f_pk_reg, f_pcp_reg, in_data[7:5], in_data[4], f_vid_reg);
            rmk_next = 2'h1;
          end else if (rmk_reg == 2'h1) begin
            o_v = 1'b1; o_d = f_vid_reg[7:0];
            rmk_next = 2'h0;
          end else begin
            o_v = 1'b1; o_d = in_data;
          end
          if (in_eop) begin
            // Always append a fresh check sequence for the bytes really sent
            fpend_next = 1'b1;
            fidx_next = 2'h0;
            skip_next = 2'h0;
            rmk_next = 2'h0;
            if (st_next == ST_DATA) begin
              st_next = ST_FCS;
            end
          end
        end
      end
      default: begin
        st_next = ST_DATA;
      end
    endcase
  end

  // ****************************************
  // Registers and outputs
  // ****************************************
  // Ready is registered, so it looks one cycle ahead at the queue and FCS
  always @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      st_reg <= ST_DATA;   q_reg <= 48'h000000000000;  qcnt_reg <= 3'h0;
      pos_reg <= 4'h0;     skip_reg <= 2'h0;           rmk_reg <= 2'h0;
      fidx_reg <= 2'h0;    fpend_reg <= 1'b0;          hold_reg <= 8'h00;
      f_op_reg <= `LVTE_OP_KEEP; f_pk_reg <= 1'b1;     f_pcp_reg <= 3'h0;
      f_vid_reg <= 12'h000; f_port_reg <= 2'h0;
      in_ready_reg <= 1'b0;
      out_valid_reg <= 1'b0; out_data_reg <= 8'h00;
      out_sop_reg <= 1'b0;   out_eop_reg <= 1'b0;   out_port_reg <= 2'h0;
    end else if (ce) begin
      st_reg <= st_next;   q_reg <= q_next;            qcnt_reg <= qcnt_next;
      pos_reg <= pos_next; skip_reg <= skip_next;      rmk_reg <= rmk_next;
      fidx_reg <= fidx_next; fpend_reg <= fpend_next;  hold_reg <= hold_next;
      f_op_reg <= f_op_next; f_pk_reg <= f_pk_next;    f_pcp_reg <= f_pcp_next;
      f_vid_reg <= f_vid_next; f_port_reg <= f_port_next;
      in_ready_reg <= (st_next == ST_DATA);
      out_valid_reg <= o_v;
      out_data_reg <= o_d;
      out_sop_reg <= o_sop;
      out_eop_reg <= o_eop;
      out_port_reg <= f_port_next;
    end
  end

  // ****************************************
  // Check sequence over the outgoing bytes
  // ****************************************
  lvte_crc32 u_crc (
    .sys_clk (sys_clk),
    .rst_n   (rst_n),
    .ce      (ce),
    .en      (o_v && (st_reg != ST_FCS)),
    .init    (o_sop),
    .data    (o_d),
    .crc_reg (crc_w)
  );

endmodule // lvte_tag_editor

// >>> tb/lvte_tag_editor_properties.sv
// Concurrent checks on the tag editor's ports: config refusal, framing, FCS tail.
// Assumes ce stays high while frames run; bound from the testbench file.
`timescale 1ns/1ps

module lvte_tag_editor_properties #(
  parameter PORTS = 4
) (
  // Clock and reset
  input wire logic        sys_clk,
  input wire logic        rst_n,
  input wire logic        ce,
  // Configuration
  input wire logic        cfg_wr,
  input wire logic [1:0]  cfg_port,
  input wire logic [1:0]  cfg_op,
  input wire logic        cfg_pkeep,
  input wire logic [2:0]  cfg_pcp,
  input wire logic [11:0] cfg_vid,
  input wire logic        cfg_reject_reg,
  // Frame input
  input wire logic        in_valid,
  input wire logic [7:0]  in_data,
  input wire logic        in_sop,
  input wire logic        in_eop,
  input wire logic [1:0]  in_port,
  input wire logic        in_down,
  input wire logic        in_ready_reg,
  // Frame output
  input wire logic        out_valid_reg,
  input wire logic [7:0]  out_data_reg,
  input wire logic        out_sop_reg,
  input wire logic        out_eop_reg,
  input wire logic [1:0]  out_port_reg
);
  // ****************************************
  // Properties
  // ****************************************
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!rst_n);

  // Byte handshake and frame edges
  sequence s_take_sop; ce && in_valid && in_ready_reg && in_sop; endsequence
  sequence s_take_eop; ce && in_valid && in_ready_reg && in_eop; endsequence
  sequence s_out_sop; out_valid_reg && out_sop_reg; endsequence

  reject_bad_a: assert property (ce && cfg_wr && cfg_vid > 12'hFFE |=> cfg_reject_reg)
    else $error("out of range id not refused");
  reject_good_a: assert property (ce && !(cfg_wr && cfg_vid > 12'hFFE) |=> !cfg_reject_reg)
    else $error("refusal pulse without cause");
  first_byte_a: assert property (s_take_sop |=> s_out_sop ##0
    (out_data_reg == $past(in_data) && out_port_reg == $past(in_port)))
    else $error("first byte or port wrong");
  fcs_tail_a: assert property (out_eop_reg |-> out_valid_reg && $past(out_valid_reg) &&
    $past(out_valid_reg, 2) && $past(out_valid_reg, 3))
    else $error("fcs bytes not contiguous");
  // Ready returns with the last check byte, so a new frame may follow at once
  gap_after_a: assert property (out_eop_reg |=> (!out_valid_reg || out_sop_reg))
    else $error("frame body byte right after frame end");
  ready_fcs_a: assert property (s_take_eop |=> !in_ready_reg [*4])
    else $error("input taken during fcs");
  eop_out_a: assert property (s_take_eop |-> ##[1:20] (out_valid_reg && out_eop_reg))
    else $error("frame end not emitted");
  flag_valid_a: assert property ((out_sop_reg || out_eop_reg) |-> out_valid_reg)
    else $error("frame flag without valid");
endmodule // lvte_tag_editor_properties

// >>> tb/lvte_lan_port.sv
// LAN port receiver model: gathers each emitted frame and runs a CRC over it.
// Assumes no back-pressure toward the editor and ce held high.
`timescale 1ns/1ps

module lvte_lan_port (
  // Clock
  input wire logic       sys_clk,
  // Link byte stream
  input wire logic       out_valid_reg,
  input wire logic [7:0] out_data_reg,
  input wire logic       out_sop_reg,
  input wire logic       out_eop_reg,
  input wire logic [1:0] out_port_reg
);
  logic [7:0]  rx[$];
  logic [31:0] crc;
  logic [1:0]  port;
  int          nfr = 0;

  // Reflected CRC step; a good frame leaves the fixed residue
  function automatic logic [31:0] step(input logic [31:0] c, input logic [7:0] d);
    c = c ^ {24'h0, d};
    for (int k = 0; k < 8; k++) c = c[0] ? (c >> 1) ^ 32'hEDB88320 : c >> 1;
    return c;
  endfunction

  // Collect bytes from sop to eop
  always @(posedge sys_clk) begin
    if (out_valid_reg === 1'b1) begin
      if (out_sop_reg) begin
        rx = {};
        crc = 32'hFFFFFFFF;
        port = out_port_reg;
      end
      rx.push_back(out_data_reg);
      crc = step(crc, out_data_reg);
      if (out_eop_reg) nfr++;
    end
  end
endmodule // lvte_lan_port

// >>> tb/testbench.sv
// Self-checking bench for the tag editor: per-port config, frames, refusal.
// Assumes the LAN port model and the property checker from this folder.
`timescale 1ns/1ps
`include "lvte_consts.vh"

module testbench;
  logic        sys_clk = 0, rst_n = 0, ce = 1, cfg_wr = 0, cfg_pkeep = 0;
  logic [1:0]  cfg_port = 0, cfg_op = 0, in_port = 0;
  logic [2:0]  cfg_pcp = 0;
  logic [11:0] cfg_vid = 0;
  logic        in_valid = 0, in_sop = 0, in_eop = 0, in_down = 0;
  logic [7:0]  in_data = 0;
  wire         cfg_reject_reg, in_ready_reg, out_valid_reg, out_sop_reg, out_eop_reg;
  wire  [7:0]  out_data_reg;
  wire  [1:0]  out_port_reg;
  logic [7:0]  fin[$], fexp[$];
  int          err_count = 0, tests_run = 0;

  lvte_tag_editor #(.PORTS(4)) lvte_tag_editor_i (.*);
  lvte_lan_port lvte_lan_port_i (.*);

  // 250 MHz clock
  always #2 sys_clk = ~sys_clk;

  // ****************************************
  // Helpers
  // ****************************************
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      err_count++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic close_out();
    $display("checks %0d, errors %0d", tests_run, err_count);
    if (err_count == 0 && tests_run > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask

  task automatic cfg(input [1:0] p, input [1:0] op, input pk, input [2:0] pc, input [11:0] v);
    @(negedge sys_clk);
    {cfg_wr, cfg_port, cfg_op, cfg_pkeep, cfg_pcp, cfg_vid} = {1'b1, p, op, pk, pc, v};
    @(negedge sys_clk);
    cfg_wr = 0;
    chk(cfg_reject_reg, v > 12'hFFE);
  endtask

  // Address bytes, nt tags from the top of tags, then type and payload
  task automatic mk(input [63:0] tags, input int nt);
    fin = {};
    for (int i = 0; i < 12; i++) fin.push_back(8'(i + 1));
    for (int i = 0; i < nt * 4; i++) fin.push_back(tags[63 - 8 * i -: 8]);
    for (int i = 0; i < 4; i++) fin.push_back(8'(32'h0800A55A >> (24 - 8 * i)));
    fexp = fin;
  endtask

  // Offer bytes, hold each until ready, then judge the received frame
  task automatic send(input [1:0] p, input dn);
    int n, t;
    n = lvte_lan_port_i.nfr;
    for (int i = 0; i < fin.size(); i++) begin
      @(negedge sys_clk);
      {in_valid, in_data, in_sop, in_eop} = {1'b1, fin[i], i == 0, i == fin.size() - 1};
      {in_port, in_down} = {p, dn};
      for (t = 0; in_ready_reg !== 1'b1 && t < 99; t++) @(negedge sys_clk);
    end
    @(negedge sys_clk);
    in_valid = 0;
    for (t = 0; lvte_lan_port_i.nfr == n && t < 99; t++) @(negedge sys_clk);
    chk(lvte_lan_port_i.nfr, n + 1);
    chk(lvte_lan_port_i.port, p);
    chk(lvte_lan_port_i.rx.size(), fexp.size() + 4);
    for (int i = 0; i < fexp.size(); i++) chk(lvte_lan_port_i.rx[i], fexp[i]);
    chk(lvte_lan_port_i.crc, 32'hDEBB20E3);
  endtask

  // ****************************************
  // Scenarios
  // ****************************************
  task automatic s_add();
    cfg(1, `LVTE_OP_ADD, 0, 5, 12'hFFE);
    mk(0, 0);
    for (int i = 0; i < 4; i++) fexp.insert(12 + i, 8'(32'h8100AFFE >> (24 - 8 * i)));
    send(1, 1);
    mk(64'h8100_0007_0000_0000, 1);
    send(1, 1);
    mk(0, 0);
    send(1, 0);
  endtask

  task automatic s_remove();
    cfg(2, `LVTE_OP_REMOVE, 1, 0, 12'h000);
    mk(64'h88A8_2010_8100_3020, 2);
    for (int i = 0; i < 4; i++) fexp.delete(12);
    send(2, 1);
    mk(0, 0);
    send(2, 1);
  endtask

  task automatic s_rewrite();
    cfg(3, `LVTE_OP_REWRITE, 1, 0, 12'h123);
    cfg(3, `LVTE_OP_KEEP, 0, 7, 12'hFFF);
    mk(64'h8100_B456_0000_0000, 1);
    {fexp[14], fexp[15]} = 16'hB123;
    send(3, 1);
    cfg(3, `LVTE_OP_REWRITE, 0, 7, 12'h000);
    mk(64'h8100_B456_0000_0000, 1);
    {fexp[14], fexp[15]} = 16'hF000;
    send(3, 1);
  endtask

  task automatic s_keep();
    cfg(0, `LVTE_OP_KEEP, 0, 3, 12'h055);
    mk(64'h8100_6064_0000_0000, 1);
    send(0, 1);
  endtask

  // A write offered while ce is low must not land; port 0 stays keep
  task automatic s_freeze();
    @(negedge sys_clk);
    {ce, cfg_wr, cfg_port, cfg_op, cfg_vid} = {1'b0, 1'b1, 2'h0, `LVTE_OP_REMOVE, 12'h000};
    repeat (2) @(negedge sys_clk);
    {ce, cfg_wr} = 2'b10;
    chk(cfg_reject_reg, 0);
    mk(64'h8100_6064_0000_0000, 1);
    send(0, 1);
  endtask

  // Main sequence
  initial begin
    repeat (16) @(negedge sys_clk);
    rst_n = 1;
    repeat (2) @(negedge sys_clk);
    s_add();
    s_remove();
    s_rewrite();
    s_keep();
    s_freeze();
    close_out();
  end

  // Watchdog well past the few hundred cycles the scenarios need
  initial begin
    #40000;
    err_count++;
    close_out();
  end
endmodule // testbench

bind lvte_tag_editor lvte_tag_editor_properties #(.PORTS(PORTS)) props_i (.*);
